//--- hdl/can_obj_defines.svh
`ifndef CAN_OBJ_DEFINES_SVH
`define CAN_OBJ_DEFINES_SVH
`define ADDR_CPU_IF 8'h02
`define ADDR_BIT_TIMING_SECOND 8'h4F
`define ADDR_LAST_CTRL_A 8'hF0
`define ADDR_LAST_CTRL_B 8'hF1
`define ADDR_LAST_ARB_FIRST 8'hF2
`define ADDR_LAST_ARB_LAST 8'hF5
`define ADDR_LAST_CONFIG 8'hF6
`define ADDR_LAST_DATA_FIRST 8'hF7
`define ADDR_LAST_DATA_LAST 8'hFE
`define ADDR_UNDEF_READ 8'hFF
`define BIT_SAMPLING_SELECT 7
`define BIT_DIRECTION 3
`define POS_VALID 6
`define POS_RECEIVE_INTERRUPT_ENABLE 2
`define POS_PEND 0
`define FIELD_SET 2'b10
`define FIELD_RESET 2'b01
`define BIT_DSC 6
`define RESET_BYTE 8'h00
`define RESET_CTRL 8'h55
`define ACK_SINGLE_TQ 4'h0
`define ACK_MAJORITY_TQ 4'h1
`define ACK_LEN_CYCLES 4'h4
`endif

//--- hdl/can_obj_pkg.sv
package can_obj_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [1:0] field_t;
	typedef enum {st_idle, st_delay, st_ack} ack_state_e;
endpackage : can_obj_pkg

//--- hdl/sync2.sv
`timescale 1ns/1ps
module sync2 (
	input wire logic clk,
	input wire logic nrst,
	input wire logic d,
	output logic q
);
	logic s1_r;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_r <= 1'b0;
			q <= 1'b0;
		end else begin
			s1_r <= d;
			q <= s1_r;
		end
	end
endmodule : sync2

//--- hdl/field2.sv
`timescale 1ns/1ps
`include "can_obj_defines.svh"
// two-bit set/reset field: 10 writes set, 01 writes reset, other codes keep
module field2 (
	input wire logic clk,
	input wire logic nrst,
	input wire logic wr,
	input wire logic [1:0] wdata,
	input wire logic hw_set,
	output logic is_set
);
	logic is_set_nxt;
	// hardware set wins over a host reset in the same cycle
	assign is_set_nxt = hw_set ? 1'b1 :
		(wr && wdata == `FIELD_SET) ? 1'b1 :
		(wr && wdata == `FIELD_RESET) ? 1'b0 : is_set;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) is_set <= 1'b0;
		else is_set <= is_set_nxt;
	end
endmodule : field2

//--- hdl/can_object_ctrl.sv
`timescale 1ns/1ps
`include "can_obj_defines.svh"
// How it works
// - host writes to last object arbitration and data bytes always store.
// - those bytes read back undefined while object_valid is set.
// - a message event with enables set raises interrupt_pending and interrupt.
// - host resetting interrupt_pending drops the interrupt output.
// - host setting interrupt_pending directly never drives the interrupt.
// - matching remote frame on plain receive object raises receive-ok.
// - it also raises a receive interrupt when receive_interrupt_enable set.
// - it also queues a remote frame with the object identifier.
// - direction bit 3 at zero configures the object for reception.
// - sampling_select bit 7 picks three-sample majority, zero single.
// - majority mode starts the acknowledge one time quantum later.
// - divider setting picks the oscillator edge sampling chip select.
// - acknowledge may be missed, but the access still completes.
module can_object_ctrl (
	input wire logic clk,
	input wire logic nrst,
	input wire logic cs_n,
	input wire logic rd,
	input wire logic wr,
	input wire logic [7:0] addr,
	input wire can_obj_pkg::byte_t wdata,
	output can_obj_pkg::byte_t rdata,
	input wire logic oscillator_input,
	output logic transfer_ack_n,
	input wire logic msg_event,
	input wire logic remote_rx,
	input wire logic [28:0] remote_id,
	input wire logic [3:0] remote_dlc,
	input wire logic tq_tick,
	input wire logic ack_slot,
	output logic ack_drive,
	output logic sampling_majority,
	output logic rx_ok,
	output logic remote_tx_req,
	output logic [28:0] remote_tx_id,
	output logic interrupt_n
);
	import can_obj_pkg::*;
	default clocking chk_cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	byte_t arb_r [0:3];
	byte_t data_r [0:7];
	byte_t bit_timing_second_r, cpu_if_r, config_r, rdata_nxt;
	field_t rmt_field_r;
	logic valid_set, receive_interrupt_enable_set, pend_set, hw_pend, host_pend_r;
	logic wr_ctrl_a, wr_cfg, is_arb, is_data, remote_match, match_plain;
	logic [3:0] tq_cnt_r;
	logic osc_s, osc_d_r, osc_edge, cs_s, cs_seen_r;
	ack_state_e ack_st_r;

	assign wr_ctrl_a = wr && addr == `ADDR_LAST_CTRL_A;
	assign wr_cfg = wr && addr == `ADDR_LAST_CONFIG;
	assign is_arb = addr >= `ADDR_LAST_ARB_FIRST &&
		addr <= `ADDR_LAST_ARB_LAST;
	assign is_data = addr >= `ADDR_LAST_DATA_FIRST &&
		addr <= `ADDR_LAST_DATA_LAST;

	// object fields in the first control register
	field2 u_valid (.clk(clk), .nrst(nrst), .wr(wr_ctrl_a),
		.wdata(wdata[`POS_VALID+1:`POS_VALID]), .hw_set(1'b0),
		.is_set(valid_set));
	field2 u_receive_interrupt_enable (.clk(clk), .nrst(nrst), .wr(wr_ctrl_a),
		.wdata(wdata[`POS_RECEIVE_INTERRUPT_ENABLE+1:`POS_RECEIVE_INTERRUPT_ENABLE]), .hw_set(1'b0),
		.is_set(receive_interrupt_enable_set));
	field2 u_pend (.clk(clk), .nrst(nrst), .wr(wr_ctrl_a),
		.wdata(wdata[`POS_PEND+1:`POS_PEND]), .hw_set(hw_pend),
		.is_set(pend_set));

	// receive object with second control fields all reset
	assign match_plain = valid_set && !config_r[`BIT_DIRECTION] &&
		rmt_field_r == `FIELD_RESET;
	assign remote_match = remote_rx && match_plain &&
		remote_id == {arb_r[0], arb_r[1], arb_r[2], arb_r[3][7:3]} &&
		remote_dlc == config_r[7:4];
	assign hw_pend = (msg_event && receive_interrupt_enable_set) ||
		(remote_match && receive_interrupt_enable_set);

	// host-set pending is remembered so it never reaches the pin
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) host_pend_r <= 1'b0;
		else if (hw_pend) host_pend_r <= 1'b0;
		// a set on an already pending object must not drop the pin
		else if (wr_ctrl_a && wdata[1:0] == `FIELD_SET && !pend_set)
			host_pend_r <= 1'b1;
	end
	assign interrupt_n = !(pend_set && !host_pend_r);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_ok <= 1'b0;
			remote_tx_req <= 1'b0;
			remote_tx_id <= '0;
		end else begin
			rx_ok <= remote_match;
			remote_tx_req <= remote_match;
			if (remote_match) remote_tx_id <= remote_id;
		end
	end

	// register writes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 4; i++) arb_r[i] <= `RESET_BYTE;
			for (int i = 0; i < 8; i++) data_r[i] <= `RESET_BYTE;
			bit_timing_second_r <= `RESET_BYTE;
			cpu_if_r <= `RESET_BYTE;
			config_r <= `RESET_BYTE;
			rmt_field_r <= `FIELD_RESET;
		end else if (wr) begin
			if (is_arb)
				arb_r[2'(addr - `ADDR_LAST_ARB_FIRST)] <= wdata;
			if (is_data)
				data_r[3'(addr - `ADDR_LAST_DATA_FIRST)] <= wdata;
			if (addr == `ADDR_BIT_TIMING_SECOND) bit_timing_second_r <= wdata;
			if (addr == `ADDR_CPU_IF) cpu_if_r <= wdata;
			if (wr_cfg) config_r <= wdata;
			if (addr == `ADDR_LAST_CTRL_B) rmt_field_r <= wdata[1:0];
		end
	end

	assign sampling_majority =
		bit_timing_second_r[`BIT_SAMPLING_SELECT];

	// reads: arbitration and data undefined while the object is valid
	always_comb begin
		rdata_nxt = `RESET_BYTE;
		if (is_arb)
			rdata_nxt = valid_set ? `ADDR_UNDEF_READ :
				arb_r[2'(addr - `ADDR_LAST_ARB_FIRST)];
		else if (is_data)
			rdata_nxt = valid_set ? `ADDR_UNDEF_READ :
				data_r[3'(addr - `ADDR_LAST_DATA_FIRST)];
		else if (addr == `ADDR_LAST_CTRL_A)
			rdata_nxt = {valid_set ? `FIELD_SET : `FIELD_RESET, 2'b01,
				receive_interrupt_enable_set ? `FIELD_SET : `FIELD_RESET,
				pend_set ? `FIELD_SET : `FIELD_RESET};
		else if (addr == `ADDR_LAST_CTRL_B)
			rdata_nxt = {6'h15, rmt_field_r};
		else if (addr == `ADDR_LAST_CONFIG)
			rdata_nxt = config_r;
		else if (addr == `ADDR_BIT_TIMING_SECOND)
			rdata_nxt = bit_timing_second_r;
		else if (addr == `ADDR_CPU_IF)
			rdata_nxt = cpu_if_r;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) rdata <= `RESET_BYTE;
		else if (rd) rdata <= rdata_nxt;
	end

	// acknowledge slot timing
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack_st_r <= st_idle;
			tq_cnt_r <= 4'h0;
			ack_drive <= 1'b0;
		end else begin
			case (ack_st_r)
			st_idle: begin
				ack_drive <= 1'b0;
				if (ack_slot) begin
					if (sampling_majority) begin
						ack_st_r <= st_delay;
						tq_cnt_r <= `ACK_MAJORITY_TQ;
					end else begin
						ack_st_r <= st_ack;
						ack_drive <= 1'b1;
						tq_cnt_r <= `ACK_LEN_CYCLES;
					end
				end
			end
			st_delay: if (tq_tick) begin
				ack_st_r <= st_ack;
				ack_drive <= 1'b1;
				tq_cnt_r <= `ACK_LEN_CYCLES;
			end
			st_ack: if (tq_tick) begin
				if (tq_cnt_r == `ACK_SINGLE_TQ + 4'h1) begin
					ack_st_r <= st_idle;
					ack_drive <= 1'b0;
				end
				tq_cnt_r <= tq_cnt_r - 4'h1;
			end
			default: ack_st_r <= st_idle;
			endcase
		end
	end

	// transfer acknowledge: chip select sampled on the chosen oscillator edge
	sync2 u_osc (.clk(clk), .nrst(nrst), .d(oscillator_input), .q(osc_s));
	sync2 u_cs (.clk(clk), .nrst(nrst), .d(cs_n), .q(cs_s));
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) osc_d_r <= 1'b0;
		else osc_d_r <= osc_s;
	end
	assign osc_edge = cpu_if_r[`BIT_DSC] ? (osc_d_r && !osc_s) :
		(!osc_d_r && osc_s);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) cs_seen_r <= 1'b0;
		else if (cs_s) cs_seen_r <= 1'b0;
		else if (osc_edge) cs_seen_r <= 1'b1;
	end
	assign transfer_ack_n = !cs_seen_r;

	// acknowledge slot steps
	sequence slot_single_s;
		ack_st_r == st_idle && ack_slot && !sampling_majority;
	endsequence : slot_single_s
	sequence slot_majority_s;
		ack_st_r == st_idle && ack_slot && sampling_majority;
	endsequence : slot_majority_s
	sequence delay_done_s;
		ack_st_r == st_delay && tq_tick;
	endsequence : delay_done_s
	sequence ack_last_s;
		ack_st_r == st_ack && tq_tick && tq_cnt_r == 4'h1;
	endsequence : ack_last_s

	// interrupt pending and the interrupt pin
	a_int_clear: assert property (
		wr_ctrl_a && wdata[1:0] == `FIELD_RESET && !hw_pend
		|=> interrupt_n) else $error("interrupt not cleared");
	a_host_pend: assert property (
		wr_ctrl_a && wdata[1:0] == `FIELD_SET && !hw_pend && !pend_set
		|=> interrupt_n) else $error("host set raised interrupt");
	a_pend_keep: assert property (
		wr_ctrl_a && wdata[1:0] == `FIELD_SET && !interrupt_n
		|=> !interrupt_n) else $error("host set dropped interrupt");
	a_event_int: assert property (
		msg_event && receive_interrupt_enable_set |=> !interrupt_n)
		else $error("event gave no interrupt");
	a_event_pend: assert property (
		msg_event && receive_interrupt_enable_set |=> pend_set)
		else $error("event left pending clear");
	a_remote_int: assert property (
		remote_match && receive_interrupt_enable_set |=> pend_set && !interrupt_n)
		else $error("remote match gave no interrupt");

	// matching remote frames
	a_rx_ok: assert property (
		remote_match |=> rx_ok && remote_tx_req)
		else $error("remote match not reported");
	a_rx_quiet: assert property (
		!remote_match |=> !rx_ok && !remote_tx_req)
		else $error("remote report without match");
	a_dir_block: assert property (
		remote_rx && config_r[`BIT_DIRECTION] |=> !rx_ok)
		else $error("transmit object answered remote frame");
	a_remote_id: assert property (
		remote_match |=> remote_tx_id == $past(remote_id))
		else $error("wrong remote id");

	// register port
	a_undef_read: assert property (
		rd && is_data && valid_set |=> rdata == `ADDR_UNDEF_READ)
		else $error("valid object read back");
	a_arb_read: assert property (
		rd && addr == `ADDR_LAST_ARB_FIRST && !valid_set
		|=> rdata == $past(arb_r[0]))
		else $error("arbitration read back wrong");
	a_arb_store: assert property (
		wr && addr == `ADDR_LAST_ARB_FIRST |=> arb_r[0] == $past(wdata))
		else $error("arbitration write lost");
	a_data_store: assert property (
		wr && addr == `ADDR_LAST_DATA_FIRST |=> data_r[0] == $past(wdata))
		else $error("data write lost");
	a_sample_set: assert property (
		wr && addr == `ADDR_BIT_TIMING_SECOND
		|=> sampling_majority == $past(wdata[`BIT_SAMPLING_SELECT]))
		else $error("sampling select not taken");

	// acknowledge slot timing
	a_single_ack: assert property (
		slot_single_s |=> ack_drive && ack_st_r == st_ack)
		else $error("single ack late");
	a_major_ack: assert property (
		slot_majority_s |=> !ack_drive && ack_st_r == st_delay)
		else $error("majority ack early");
	a_delay_step: assert property (
		delay_done_s |=> ack_drive && tq_cnt_r == `ACK_LEN_CYCLES)
		else $error("delayed ack not started");
	a_ack_end: assert property (
		ack_last_s |=> !ack_drive && ack_st_r == st_idle)
		else $error("ack not ended");
	a_ack_state: assert property (
		ack_drive |-> ack_st_r == st_ack)
		else $error("ack driven outside slot");

	// transfer acknowledge
	a_cs_ack: assert property (
		!cs_s && osc_edge |=> !transfer_ack_n)
		else $error("transfer ack missed");
	a_ack_wait: assert property (
		!cs_seen_r && !osc_edge |=> transfer_ack_n)
		else $error("transfer ack off edge");
	a_cs_release: assert property (
		cs_s |=> transfer_ack_n)
		else $error("transfer ack held");
endmodule : can_object_ctrl

//--- test/can_node_model.sv
`timescale 1ns/1ps
module can_node_model (
	input wire logic clk,
	output logic msg_event,
	output logic remote_rx,
	output logic [28:0] remote_id,
	output logic [3:0] remote_dlc,
	output logic tq_tick,
	output logic ack_slot
);
	logic [1:0] tq_cnt = 2'h0;
	initial begin
		msg_event = 1'b0;
		remote_rx = 1'b0;
		remote_id = 29'h0;
		remote_dlc = 4'h0;
		tq_tick = 1'b0;
		ack_slot = 1'b0;
	end
	// one time quantum is four clocks
	always @(posedge clk) begin
		tq_cnt <= tq_cnt + 2'h1;
		tq_tick <= (tq_cnt == 2'h3);
	end
	task automatic pulse_event();
		msg_event <= 1'b1;
		@(posedge clk);
		msg_event <= 1'b0;
	endtask : pulse_event
	task automatic send_remote(input logic [28:0] id, input logic [3:0] dlc);
		remote_rx <= 1'b1;
		remote_id <= id;
		remote_dlc <= dlc;
		@(posedge clk);
		remote_rx <= 1'b0;
		// frame over: identifier lines no longer hold the last value
		remote_id <= ~id;
		remote_dlc <= ~dlc;
	endtask : send_remote
	// ack slot opens one clock after the caller has seen a quantum tick
	task automatic send_ack();
		@(posedge clk);
		ack_slot <= 1'b1;
		@(posedge clk);
		ack_slot <= 1'b0;
	endtask : send_ack
endmodule : can_node_model

//--- test/can_message_object_control_bench.sv
`timescale 1ns/1ps
`include "can_obj_defines.svh"
module can_message_object_control_bench;
	import can_obj_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic cs_n = 1'b1;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic oscillator_input = 1'b0;
	logic [2:0] oc = 3'h0;
	logic [7:0] addr = 8'h00;
	byte_t wdata = 8'h00;
	byte_t rdata;
	byte_t mem [15];
	logic transfer_ack_n, ack_drive, sampling_majority, rx_ok;
	logic remote_tx_req, interrupt_n, msg_event, remote_rx, tq_tick, ack_slot;
	logic [28:0] remote_id, remote_tx_id, rid;
	logic [3:0] remote_dlc;
	int err_count = 0;
	int checks = 0;
	int i, n, v;
	always #2 clk = ~clk;
	always @(posedge clk) begin
		oc <= oc + 3'h1;
		oscillator_input <= oc[2];
	end
	can_node_model node (.clk, .msg_event, .remote_rx, .remote_id,
		.remote_dlc, .tq_tick, .ack_slot);
	can_object_ctrl dut (.clk, .nrst, .cs_n, .rd, .wr, .addr, .wdata, .rdata,
		.oscillator_input, .transfer_ack_n, .msg_event, .remote_rx, .remote_id,
		.remote_dlc, .tq_tick, .ack_slot, .ack_drive, .sampling_majority,
		.rx_ok, .remote_tx_req, .remote_tx_id, .interrupt_n);
	task automatic give_verdict();
		$display("mismatches %0d comparisons %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	task automatic chk_bit(input string what, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %b got %b", what, e, g);
		end
	endtask : chk_bit
	task automatic chk_val(input string what, input logic [28:0] e,
		input logic [28:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", what, e, g);
		end
	endtask : chk_val
	task automatic wait_cap(input int k);
		if (k >= 40) begin
			err_count++;
			$display("CHECK FAILED wait exp done got timeout");
			give_verdict();
		end
	endtask : wait_cap
	task automatic wr_reg(input logic [7:0] a, input byte_t d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, input byte_t e);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		#1;
		chk_val("rdata", 29'(e), 29'(rdata));
		@(posedge clk);
	endtask : rd_reg
	initial begin
		void'($urandom(32'he74b_b918));
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		#1;
		chk_bit("interrupt_n", 1'b1, interrupt_n);
		chk_bit("transfer_ack_n", 1'b1, transfer_ack_n);
		chk_val("rdata", 29'h0, 29'(rdata));
		@(posedge clk);
		wr_reg(`ADDR_LAST_CTRL_A, 8'h80);
		for (i = 2; i < 15; i++) begin
			mem[i] = 8'($urandom);
			if (i != 6) wr_reg(8'(8'hF0 + i), mem[i]);
		end
		for (v = 1; v >= 0; v--) begin
			if (v == 0) wr_reg(`ADDR_LAST_CTRL_A, 8'h40);
			for (i = 2; i < 15; i++)
				if (i != 6) rd_reg(8'(8'hF0 + i), v ? 8'hFF : mem[i]);
		end
		rd_reg(8'h80, 8'h00);
		$display("test readback done");
		wr_reg(`ADDR_LAST_CTRL_A, 8'h88);
		node.pulse_event();
		#1;
		chk_bit("interrupt_n", 1'b0, interrupt_n);
		@(posedge clk);
		wr_reg(`ADDR_LAST_CTRL_A, 8'h02);
		chk_bit("interrupt_n", 1'b0, interrupt_n);
		wr_reg(`ADDR_LAST_CTRL_A, 8'h01);
		chk_bit("interrupt_n", 1'b1, interrupt_n);
		wr_reg(`ADDR_LAST_CTRL_A, 8'h02);
		chk_bit("interrupt_n", 1'b1, interrupt_n);
		wr_reg(`ADDR_LAST_CTRL_A, 8'h01);
		$display("test pending done");
		rid = {mem[2], mem[3], mem[4], mem[5][7:3]};
		wr_reg(`ADDR_LAST_CTRL_A, 8'h80);
		wr_reg(`ADDR_LAST_CTRL_B, 8'h55);
		for (v = 0; v < 2; v++) begin
			n = $urandom_range(8);
			wr_reg(`ADDR_LAST_CONFIG, {4'(n), 1'(v), 3'h0});
			node.send_remote(rid, 4'(n));
			#1;
			chk_bit("rx_ok", v == 0, rx_ok);
			chk_bit("interrupt_n", 1'(v), interrupt_n);
			chk_bit("remote_tx_req", v == 0, remote_tx_req);
			if (v == 0) chk_val("remote_tx_id", rid, remote_tx_id);
			@(posedge clk);
			wr_reg(`ADDR_LAST_CTRL_A, 8'h01);
		end
		$display("test remote done");
		for (v = 0; v < 2; v++) begin
			wr_reg(`ADDR_BIT_TIMING_SECOND, v ? 8'h80 : 8'h00);
			chk_bit("sampling_majority", 1'(v), sampling_majority);
			for (i = 0; i < 40 && tq_tick !== 1'b1; i++) @(posedge clk);
			wait_cap(i);
			node.send_ack();
			#1;
			n = 0;
			for (i = 0; i < 40 && ack_drive !== 1'b1; i++) begin
				if (tq_tick) n++;
				@(posedge clk);
				#1;
			end
			wait_cap(i);
			chk_val("ack_quanta", 29'(v), 29'(n));
			repeat (40) @(posedge clk);
		end
		wr_reg(`ADDR_BIT_TIMING_SECOND, 8'h00);
		$display("test ack done");
		for (v = 0; v < 2; v++) begin
			wr_reg(`ADDR_CPU_IF, v ? 8'h40 : 8'h00);
			cs_n <= 1'b0;
			for (i = 0; i < 40 && transfer_ack_n !== 1'b0; i++) begin
				@(posedge clk);
				#1;
			end
			wait_cap(i);
			chk_bit("transfer_ack_n", 1'b0, transfer_ack_n);
			chk_bit("osc_level", v == 0, oscillator_input);
			@(posedge clk);
			cs_n <= 1'b1;
			for (i = 0; i < 40 && transfer_ack_n !== 1'b1; i++) @(posedge clk);
			wait_cap(i);
			rd_reg(`ADDR_CPU_IF, v ? 8'h40 : 8'h00);
		end
		$display("test transfer ack done");
		give_verdict();
	end
endmodule : can_message_object_control_bench
